// ===== ee_pkg.sv
// Overview of operation
// - Master sends selection byte first, MSB first
// - Selection byte: type, strap field, direction
// - Respond only on type and strap match
// - Direction bit one reads, zero writes
// - Ack match in ninth bit, else stand-by
// - Address is two bytes, high first
// - Write selection: ack, two address bytes
// - Inhibit high before data blocks data
// - Byte write acked only when permitted
// - Up to 128 bytes within one row
// - Write data increments only low seven address bits
// - Write cycle only on tenth-slot STOP
// - Busy device ignores bus, never acks
// - Master polls selection until acknowledged
// - Reads ignore the write-inhibit level
// - Random read: dummy write, restart, read
// - Current read outputs counter, then increments
// - Inhibit still acks selection and address
// - Master ack fetches next byte, wraps
// - Master nack returns device to stand-by
package ee_pkg;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QUARTER_CYCLES = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_TIME_NS = 1000000;
	localparam int unsigned WRITE_CYCLES_DEF = WRITE_TIME_NS / CLK_PERIOD_NS;
	// ************************************************************
	// Framing and memory shape
	// ************************************************************
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int unsigned PAGE_BYTES = 128;
	localparam logic [5:0] SLAVE_SYNC_INIT = 6'h03;
	localparam logic [0:0] MASTER_SYNC_INIT = 1'h1;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SELECT = 3'h1,
		ST_ADDR_HI = 3'h3,
		ST_ADDR_LO = 3'h2,
		ST_WRITE = 3'h6,
		ST_READ = 3'h5
	} slave_state_t;
	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_START = 2'h1,
		M_XFER = 2'h3,
		M_STOP = 2'h2
	} master_state_t;
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_STOP = 2'h1,
		OP_WRITE = 2'h2,
		OP_READ = 2'h3
	} op_t;
endpackage : ee_pkg

// ===== twi_if.sv
`timescale 1ns/10ps
// Two-wire link; the line levels are resolved here from the drivers' enables
interface twi_if;
	logic sclM;
	logic sclMOe;
	logic sdaM;
	logic sdaMOe;
	logic sdaS;
	logic sdaSOe;
	logic scl;
	logic sda;
	// Open drain data with pull-up; clock pulled up when the master lets go
	assign scl = sclMOe ? sclM : 1'b1;
	assign sda = !((sdaMOe && !sdaM) || (sdaSOe && !sdaS));
	modport master (output sclM, output sclMOe, output sdaM, output sdaMOe, input scl, input sda);
	modport slave (output sdaS, output sdaSOe, input scl, input sda);
endinterface : twi_if

// ===== pin_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser; a change is taken once stages two and three agree
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	// Stage one feeds stage two only, so no glitch reaches the logic
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
		end else if (ce) begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// Per-bit agreement filter
	for (genvar i = 0; i < WIDTH; i++) begin : g_filt
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				dout[i] <= INIT[i];
			end else if (ce && s2_q[i] == s3_q[i]) begin
				dout[i] <= s3_q[i];
			end
		end
	end
endmodule : pin_sync

// ===== eeprom_slave.sv
`timescale 1ns/10ps
module eeprom_slave #(
	parameter int unsigned WRITE_CYCLES = ee_pkg::WRITE_CYCLES_DEF,
	parameter logic [3:0] DEV_TYPE = 4'h5 // Arbitrary type code
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [2:0] bus_slot_select_pins,
	input wire logic write_inhibit_pin,
	output logic writeBusy,
	twi_if.slave bus
);
	// ************************************************************
	// Input conditioning and bus events
	// ************************************************************
	logic [5:0] pinsF;
	logic wiF;
	logic [2:0] slotF;
	logic sclF;
	logic sdaF;
	logic sclPrev_q;
	logic sdaPrev_q;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;

	pin_sync #(.WIDTH(6), .INIT(ee_pkg::SLAVE_SYNC_INIT)) uSync (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.din({write_inhibit_pin, bus_slot_select_pins, bus.scl, bus.sda}),
		.dout(pinsF)
	);
	assign {wiF, slotF, sclF, sdaF} = pinsF;

	// Previous levels for edge and condition detection
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else if (ce) begin
			sclPrev_q <= sclF;
			sdaPrev_q <= sdaF;
		end
	end

	// While busy START and STOP are masked, so no condition is seen
	assign sclRise = sclF && !sclPrev_q;
	assign sclFall = !sclF && sclPrev_q;
	assign startCond = sclF && sclPrev_q && sdaPrev_q && !sdaF && !writeBusy;
	assign stopCond = sclF && sclPrev_q && !sdaPrev_q && sdaF && !writeBusy;

	// ************************************************************
	// Byte framing
	// ************************************************************
	ee_pkg::slave_state_t state_q;
	logic [3:0] bitCnt_q;
	logic inAck_q;
	logic afterAck_q;
	logic ackSeen_q;
	logic wiSeen_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic [15:0] addr_q;
	logic [7:0] pageBuf [ee_pkg::PAGE_BYTES];
	logic [ee_pkg::PAGE_BYTES-1:0] pageMask_q;
	logic [7:0] mem [65536];
	logic [31:0] busyCnt_q;
	logic byteDone;
	logic ackEnd;
	logic selOk;
	logic dataOk;
	logic commit;

	assign byteDone = sclFall && bitCnt_q == ee_pkg::BYTE_BITS && !inAck_q;
	assign ackEnd = sclFall && inAck_q;
	assign selOk = rx_q[7:4] == DEV_TYPE && rx_q[3:1] == slotF;
	assign dataOk = state_q == ee_pkg::ST_WRITE && !wiSeen_q;
	// An empty page, as after an inhibited write, starts no cycle
	assign commit = stopCond && afterAck_q && state_q == ee_pkg::ST_WRITE && |pageMask_q;

	// Bit counter and acknowledge slot; bits are taken on the rising clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bitCnt_q <= '0;
			inAck_q <= 1'b0;
			rx_q <= '0;
		end else if (ce) begin
			if (startCond) begin
				bitCnt_q <= '0;
				inAck_q <= 1'b0;
			end else if (state_q != ee_pkg::ST_IDLE) begin
				if (sclRise && !inAck_q && bitCnt_q < ee_pkg::BYTE_BITS) begin
					rx_q <= {rx_q[6:0], sdaF};
					bitCnt_q <= bitCnt_q + 4'h1;
				end
				if (byteDone) begin
					inAck_q <= 1'b1;
				end else if (ackEnd) begin
					inAck_q <= 1'b0;
					bitCnt_q <= '0;
				end
			end
		end
	end

	// ************************************************************
	// Command sequencing
	// ************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ee_pkg::ST_IDLE;
		end else if (ce) begin
			if (startCond) begin
				state_q <= ee_pkg::ST_SELECT;
			end else if (stopCond) begin
				state_q <= ee_pkg::ST_IDLE;
			end else if (byteDone) begin
				unique case (state_q)
					ee_pkg::ST_SELECT: begin
						if (!selOk) begin
							state_q <= ee_pkg::ST_IDLE;
						end else if (rx_q[0]) begin
							state_q <= ee_pkg::ST_READ;
						end else begin
							state_q <= ee_pkg::ST_ADDR_HI;
						end
					end
					ee_pkg::ST_ADDR_HI: state_q <= ee_pkg::ST_ADDR_LO;
					ee_pkg::ST_ADDR_LO: state_q <= ee_pkg::ST_WRITE;
					ee_pkg::ST_WRITE: state_q <= ee_pkg::ST_WRITE;
					ee_pkg::ST_READ: state_q <= ee_pkg::ST_READ;
					ee_pkg::ST_IDLE: state_q <= ee_pkg::ST_IDLE;
				endcase
			end else if (ackEnd && state_q == ee_pkg::ST_READ && !ackSeen_q) begin
				state_q <= ee_pkg::ST_IDLE;
			end
		end
	end

	// Write-inhibit is watched from START through the low address byte
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wiSeen_q <= 1'b0;
		end else if (ce) begin
			if (startCond) begin
				wiSeen_q <= wiF;
			end else if (state_q inside {ee_pkg::ST_SELECT, ee_pkg::ST_ADDR_HI,
					ee_pkg::ST_ADDR_LO}) begin
				wiSeen_q <= wiSeen_q | wiF;
			end
		end
	end

	// Tenth-slot tracking and the master's answer after a read byte
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			afterAck_q <= 1'b0;
			ackSeen_q <= 1'b0;
		end else if (ce) begin
			// The tenth slot lasts until the clock falls again after the ack
			if (startCond || (sclFall && !inAck_q)) begin
				afterAck_q <= 1'b0;
			end else if (ackEnd) begin
				afterAck_q <= 1'b1;
			end
			// During the selection ack our own pull-down reads as an ack
			if (sclRise && inAck_q && state_q == ee_pkg::ST_READ) begin
				ackSeen_q <= !sdaF;
			end
		end
	end

	// ************************************************************
	// Address counter, kept across transactions
	// ************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			addr_q <= '0;
		end else if (ce) begin
			if (byteDone && state_q == ee_pkg::ST_ADDR_HI) begin
				addr_q[15:8] <= rx_q;
			end else if (byteDone && state_q == ee_pkg::ST_ADDR_LO) begin
				addr_q[7:0] <= rx_q;
			end else if (byteDone && dataOk) begin
				addr_q[6:0] <= addr_q[6:0] + 7'h01;
			end else if (ackEnd && state_q == ee_pkg::ST_READ && ackSeen_q) begin
				addr_q <= addr_q + 16'h0001;
			end
		end
	end

	// ************************************************************
	// Page latches and self-timed write cycle
	// ************************************************************
	// Latches hold one row; rolling over simply rewrites earlier slots
	always_ff @(posedge clk) begin
		if (ce && byteDone && dataOk) begin
			pageBuf[addr_q[6:0]] <= rx_q;
		end
	end

	// Any START drops latched data; none is seen while busy, so polling is safe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pageMask_q <= '0;
		end else if (ce) begin
			if (byteDone && dataOk) begin
				pageMask_q[addr_q[6:0]] <= 1'b1;
			end else if (startCond || (writeBusy && busyCnt_q == WRITE_CYCLES - 1)) begin
				pageMask_q <= '0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			writeBusy <= 1'b0;
			busyCnt_q <= '0;
		end else if (ce) begin
			if (commit) begin
				writeBusy <= 1'b1;
				busyCnt_q <= '0;
			end else if (writeBusy) begin
				busyCnt_q <= busyCnt_q + 32'h1;
				if (busyCnt_q == WRITE_CYCLES - 1) begin
					writeBusy <= 1'b0;
				end
			end
		end
	end

	// Copy one latch per cycle at the start of the busy time
	always_ff @(posedge clk) begin
		if (ce && writeBusy && busyCnt_q < ee_pkg::PAGE_BYTES && pageMask_q[busyCnt_q[6:0]]) begin
			mem[{addr_q[15:7], busyCnt_q[6:0]}] <= pageBuf[busyCnt_q[6:0]];
		end
	end

	// ************************************************************
	// Data line drive: acks and read data, changed on falling clock
	// ************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus.sdaSOe <= 1'b0;
			bus.sdaS <= 1'b0;
			tx_q <= '0;
		end else if (ce) begin
			bus.sdaS <= 1'b0;
			if (startCond || stopCond || writeBusy) begin
				bus.sdaSOe <= 1'b0;
			end else if (byteDone) begin
				unique case (state_q)
					ee_pkg::ST_SELECT: bus.sdaSOe <= selOk;
					ee_pkg::ST_ADDR_HI, ee_pkg::ST_ADDR_LO: bus.sdaSOe <= 1'b1;
					ee_pkg::ST_WRITE: bus.sdaSOe <= dataOk;
					ee_pkg::ST_READ, ee_pkg::ST_IDLE: bus.sdaSOe <= 1'b0;
				endcase
			end else if (ackEnd) begin
				// Read data never depends on the inhibit pin
				if (state_q == ee_pkg::ST_READ && ackSeen_q) begin
					tx_q <= mem[addr_q];
					bus.sdaSOe <= !mem[addr_q][7];
				end else begin
					bus.sdaSOe <= 1'b0;
				end
			end else if (sclFall && state_q == ee_pkg::ST_READ && !inAck_q) begin
				tx_q <= {tx_q[6:0], 1'b0};
				bus.sdaSOe <= !tx_q[6];
			end
		end
	end
endmodule : eeprom_slave

// ===== twi_master.sv
`timescale 1ns/10ps
module twi_master (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic cmdValid,
	input wire ee_pkg::op_t cmdOp,
	input wire logic [7:0] cmdData,
	input wire logic cmdAck,
	output logic cmdReady,
	output logic rspValid,
	output logic [7:0] rspData,
	output logic rspAck,
	twi_if.master bus
);
	// ************************************************************
	// Quarter-bit timebase and line sampling
	// ************************************************************
	logic [7:0] divCnt_q;
	logic tick;
	logic sdaF;
	ee_pkg::master_state_t state_q;
	ee_pkg::op_t op_q;
	logic [1:0] phase_q;
	logic [3:0] bit_q;
	logic [7:0] tx_q;
	logic ackOut_q;
	logic lastBit;

	pin_sync #(.WIDTH(1), .INIT(ee_pkg::MASTER_SYNC_INIT)) uSync (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.din(bus.sda),
		.dout(sdaF)
	);

	// Free-running divider keeps the clock period fixed between commands
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			divCnt_q <= '0;
		end else if (ce) begin
			divCnt_q <= tick ? 8'h00 : divCnt_q + 8'h01;
		end
	end
	assign tick = divCnt_q == 8'(ee_pkg::QUARTER_CYCLES - 1);
	assign lastBit = bit_q == ee_pkg::BYTE_BITS;

	// ************************************************************
	// Sequencer: one START, STOP or byte with its ninth bit per command
	// ************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ee_pkg::M_IDLE;
			op_q <= ee_pkg::OP_START;
			phase_q <= '0;
			bit_q <= '0;
			tx_q <= '0;
			ackOut_q <= 1'b0;
			cmdReady <= 1'b1;
			rspValid <= 1'b0;
		end else if (ce) begin
			rspValid <= 1'b0;
			if (state_q == ee_pkg::M_IDLE) begin
				if (cmdValid && cmdReady) begin
					op_q <= cmdOp;
					tx_q <= cmdData;
					ackOut_q <= cmdAck;
					bit_q <= '0;
					phase_q <= '0;
					cmdReady <= 1'b0;
					unique case (cmdOp)
						ee_pkg::OP_START: state_q <= ee_pkg::M_START;
						ee_pkg::OP_STOP: state_q <= ee_pkg::M_STOP;
						ee_pkg::OP_WRITE, ee_pkg::OP_READ: state_q <= ee_pkg::M_XFER;
					endcase
				end
			end else if (tick) begin
				phase_q <= phase_q + 2'h1;
				if (phase_q == 2'h3) begin
					if (state_q == ee_pkg::M_XFER && !lastBit) begin
						bit_q <= bit_q + 4'h1;
						tx_q <= {tx_q[6:0], 1'b0};
					end else begin
						state_q <= ee_pkg::M_IDLE;
						cmdReady <= 1'b1;
						rspValid <= 1'b1;
					end
				end
			end
		end
	end

	// ************************************************************
	// Pin drive: byte data changes only while the clock is low; START and STOP change it with the clock high
	// ************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus.sclM <= 1'b1;
			bus.sclMOe <= 1'b1;
			bus.sdaM <= 1'b0;
			bus.sdaMOe <= 1'b0;
		end else if (ce && tick && state_q != ee_pkg::M_IDLE) begin
			bus.sclMOe <= 1'b1;
			bus.sdaM <= 1'b0;
			unique case (phase_q)
				2'h0: begin
					if (state_q == ee_pkg::M_START) begin
						bus.sdaMOe <= 1'b0;
					end else if (state_q == ee_pkg::M_STOP) begin
						bus.sdaMOe <= 1'b1;
					end else if (lastBit) begin
						// Ninth bit: release for the device, or ack or nack a read
						bus.sdaMOe <= op_q == ee_pkg::OP_READ && ackOut_q;
					end else begin
						bus.sdaMOe <= op_q == ee_pkg::OP_WRITE && !tx_q[7];
					end
				end
				2'h1: bus.sclM <= 1'b1;
				2'h2: begin
					if (state_q == ee_pkg::M_START) begin
						bus.sdaMOe <= 1'b1;
					end else if (state_q == ee_pkg::M_STOP) begin
						bus.sdaMOe <= 1'b0;
					end
				end
				2'h3: begin
					if (state_q != ee_pkg::M_STOP) begin
						bus.sclM <= 1'b0;
					end
				end
			endcase
		end
	end

	// Sample data and the device's acknowledge at mid high clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rspData <= '0;
			rspAck <= 1'b0;
		end else if (ce && tick && state_q == ee_pkg::M_XFER && phase_q == 2'h2) begin
			if (lastBit) begin
				rspAck <= !sdaF;
			end else begin
				rspData <= {rspData[6:0], sdaF};
			end
		end
	end
endmodule : twi_master

// ===== serial_eeprom_slave_access_properties.sv
`timescale 1ns/10ps
// ************************************************************
// Link checker beside the two-wire interface
// ************************************************************
module serial_eeprom_slave_access_properties #(
	parameter int unsigned WRITE_CYCLES = 3000
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sclM,
	input wire logic sclMOe,
	input wire logic sdaM,
	input wire logic sdaMOe,
	input wire logic sdaS,
	input wire logic sdaSOe,
	input wire logic scl,
	input wire logic sda,
	input wire logic writeBusy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	int unsigned busyCnt_q;

	// Length of the self-timed cycle, counted in clk cycles
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busyCnt_q <= 0;
		end else begin
			busyCnt_q <= writeBusy ? busyCnt_q + 1 : 0;
		end
	end

	property p_slaveLowOnly;
		sdaSOe |-> !sdaS;
	endproperty
	a_slaveLowOnly: assert property (p_slaveLowOnly)
		else $error("slave drives data high");
	property p_busyQuiet;
		writeBusy |-> !sdaSOe;
	endproperty
	a_busyQuiet: assert property (p_busyQuiet)
		else $error("slave drives bus while busy");
	property p_slaveEdge;
		$changed(sdaSOe) |-> !scl;
	endproperty
	a_slaveEdge: assert property (p_slaveEdge)
		else $error("slave data changed with clock high");
	property p_ackHold;
		$rose(scl) && sdaSOe |-> sdaSOe [*8];
	endproperty
	a_ackHold: assert property (p_ackHold)
		else $error("slave drive dropped with clock high");
	property p_noContention;
		$rose(scl) |-> !(sdaMOe && sdaSOe);
	endproperty
	a_noContention: assert property (p_noContention)
		else $error("both ends drive data at clock rise");
	property p_busyLen;
		$fell(writeBusy) |-> busyCnt_q == WRITE_CYCLES;
	endproperty
	a_busyLen: assert property (p_busyLen)
		else $error("write cycle length wrong");
	property p_busyAfterStop;
		$rose(writeBusy) |-> scl && sda && !$past(sda, 20);
	endproperty
	a_busyAfterStop: assert property (p_busyAfterStop)
		else $error("write cycle started without stop");
	property p_startQuiet;
		$fell(sda) && scl |-> !sdaSOe;
	endproperty
	a_startQuiet: assert property (p_startQuiet)
		else $error("slave holds data at start");
	property p_sclHigh;
		$rose(scl) |-> sclMOe [*8] ##0 scl [*8];
	endproperty
	a_sclHigh: assert property (p_sclHigh)
		else $error("clock high phase too short");
endmodule : serial_eeprom_slave_access_properties

// ===== serial_eeprom_slave_access_test.sv
`timescale 1ns/10ps
module serial_eeprom_slave_access_test;
	localparam logic [3:0] TYPE_CODE = 4'h5; // Arbitrary type code
	localparam logic [2:0] STRAP = 3'h5;
	localparam int unsigned WCYC = 3000; // Long enough to poll during a cycle
	logic clk, rstn, cmdValid, cmdAck, inhibitPin, cmdReady, rspValid, rspAck, writeBusy;
	logic [2:0] slotPins;
	logic [7:0] cmdData, rspData;
	ee_pkg::op_t cmdOp;
	int n_fail, checked;
	twi_if link();

	// ************************************************************
	// Both ends and the checker
	// ************************************************************
	eeprom_slave #(.WRITE_CYCLES(WCYC), .DEV_TYPE(TYPE_CODE)) i_eeprom_slave (.clk(clk),
		.rstn(rstn), .ce(1'b1), .bus_slot_select_pins(slotPins),
		.write_inhibit_pin(inhibitPin), .writeBusy(writeBusy), .bus(link));
	twi_master i_twi_master (.clk(clk), .rstn(rstn), .ce(1'b1), .cmdValid(cmdValid),
		.cmdOp(cmdOp), .cmdData(cmdData), .cmdAck(cmdAck), .cmdReady(cmdReady),
		.rspValid(rspValid), .rspData(rspData), .rspAck(rspAck), .bus(link));
	serial_eeprom_slave_access_properties #(.WRITE_CYCLES(WCYC)) i_props (.clk(clk),
		.rstn(rstn), .sclM(link.sclM), .sclMOe(link.sclMOe), .sdaM(link.sdaM),
		.sdaMOe(link.sdaMOe), .sdaS(link.sdaS), .sdaSOe(link.sdaSOe), .scl(link.scl),
		.sda(link.sda), .writeBusy(writeBusy));

	// ************************************************************
	// Access tasks
	// ************************************************************
	task automatic results();
		$display("Checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Bounded waits: a hang is counted and closes the run
	task automatic hang();
		n_fail++;
		$display("BAD wait expected done seen timeout");
		results();
	endtask : hang

	// One command, held until taken, then wait for its completion pulse
	task automatic cmd(input ee_pkg::op_t op, input logic [7:0] d, input logic a);
		int i;
		cmdOp <= op;
		cmdData <= d;
		cmdAck <= a;
		cmdValid <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (cmdReady !== 1'b1 && i < 100);
		if (cmdReady !== 1'b1) hang();
		cmdValid <= 1'b0;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (rspValid !== 1'b1 && i < 2000);
		if (rspValid !== 1'b1) hang();
	endtask : cmd

	task automatic waitBusy(input logic lvl);
		int i;
		for (i = 0; i < 4000 && writeBusy !== lvl; i++) @(posedge clk);
		if (i >= 4000) hang();
	endtask : waitBusy

	task automatic sel(input logic [2:0] strap, input logic rw, input logic exp);
		cmd(ee_pkg::OP_START, 8'h00, 1'b0);
		cmd(ee_pkg::OP_WRITE, {TYPE_CODE, strap, rw}, 1'b0);
		check("select ack", {7'h00, rspAck}, {7'h00, exp});
	endtask : sel

	// Address high byte first, each one acknowledged even when inhibited
	task automatic setAddr(input logic [15:0] a);
		sel(STRAP, 1'b0, 1'b1);
		cmd(ee_pkg::OP_WRITE, a[15:8], 1'b0);
		check("addr hi ack", {7'h00, rspAck}, 8'h01);
		cmd(ee_pkg::OP_WRITE, a[7:0], 1'b0);
		check("addr lo ack", {7'h00, rspAck}, 8'h01);
	endtask : setAddr

	task automatic writeRun(input logic [15:0] a, input int n, input logic [7:0] b, input logic ok);
		setAddr(a);
		for (int k = 0; k < n; k++) begin
			cmd(ee_pkg::OP_WRITE, b + 8'(k), 1'b0);
			check("data ack", {7'h00, rspAck}, {7'h00, ok});
		end
	endtask : writeRun

	// Master acks all but the last byte, then stops
	task automatic readAt(input logic [15:0] a, input int n, input logic [7:0] b);
		setAddr(a);
		sel(STRAP, 1'b1, 1'b1);
		for (int k = 0; k < n; k++) begin
			cmd(ee_pkg::OP_READ, 8'h00, k < n - 1);
			check("read data", rspData, b + 8'(k));
		end
		cmd(ee_pkg::OP_STOP, 8'h00, 1'b0);
	endtask : readAt

	// ************************************************************
	// Clock and stimulus
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		rstn = 1'b0;
		cmdValid = 1'b0;
		cmdAck = 1'b0;
		cmdData = 8'h00;
		cmdOp = ee_pkg::OP_START;
		inhibitPin = 1'b0;
		slotPins = STRAP;
		n_fail = 0;
		checked = 0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (int s = 0; s < 8; s++) begin
			sel(3'(s), 1'b0, 3'(s) == STRAP);
			cmd(ee_pkg::OP_STOP, 8'h00, 1'b0);
		end
		cmd(ee_pkg::OP_START, 8'h00, 1'b0);
		cmd(ee_pkg::OP_WRITE, {~TYPE_CODE, STRAP, 1'b0}, 1'b0);
		check("wrong type ack", {7'h00, rspAck}, 8'h00);
		cmd(ee_pkg::OP_STOP, 8'h00, 1'b0);
		check("busy after bare stop", {7'h00, writeBusy}, 8'h00);
		// Byte write, then poll while the cycle runs
		writeRun(16'h1234, 1, 8'ha5, 1'b1);
		cmd(ee_pkg::OP_STOP, 8'h00, 1'b0);
		waitBusy(1'b1);
		sel(STRAP, 1'b0, 1'b0);
		cmd(ee_pkg::OP_STOP, 8'h00, 1'b0);
		waitBusy(1'b0);
		sel(STRAP, 1'b0, 1'b1);
		cmd(ee_pkg::OP_STOP, 8'h00, 1'b0);
		readAt(16'h1234, 1, 8'ha5);
		// Page write crossing the row end wraps to the row start
		writeRun(16'h027f, 5, 8'h10, 1'b1);
		cmd(ee_pkg::OP_STOP, 8'h00, 1'b0);
		waitBusy(1'b1);
		waitBusy(1'b0);
		inhibitPin <= 1'b1;
		readAt(16'h027f, 1, 8'h10);
		readAt(16'h0200, 3, 8'h11);
		sel(STRAP, 1'b1, 1'b1);
		cmd(ee_pkg::OP_READ, 8'h00, 1'b0);
		check("current read", rspData, 8'h14);
		cmd(ee_pkg::OP_STOP, 8'h00, 1'b0);
		// Inhibited write: data refused, no cycle
		writeRun(16'h0203, 1, 8'hee, 1'b0);
		cmd(ee_pkg::OP_STOP, 8'h00, 1'b0);
		repeat (20) @(posedge clk);
		check("busy when inhibited", {7'h00, writeBusy}, 8'h00);
		inhibitPin <= 1'b0;
		// Restart before stop discards the latched byte
		writeRun(16'h0203, 1, 8'h77, 1'b1);
		cmd(ee_pkg::OP_START, 8'h00, 1'b0);
		cmd(ee_pkg::OP_STOP, 8'h00, 1'b0);
		repeat (20) @(posedge clk);
		check("busy after restart", {7'h00, writeBusy}, 8'h00);
		readAt(16'h0203, 1, 8'h14);
		results();
	end
endmodule : serial_eeprom_slave_access_test
